// ==== common/opt_pkg.sv ====
// Package: register map, reset values and carrier types for output/power/timing control
package opt_pkg;
  // Register offsets
  localparam logic [7:0] OFS_OUT  = 8'h26;
  localparam logic [7:0] OFS_CFG  = 8'h27;
  localparam logic [7:0] OFS_VHD  = 8'h28;
  localparam logic [7:0] OFS_HDL  = 8'h29;
  localparam logic [7:0] OFS_LWH  = 8'h2a;
  localparam logic [7:0] OFS_LWL  = 8'h2b;
  localparam logic [7:0] OFS_SHH  = 8'h2c;
  localparam logic [7:0] OFS_SHL  = 8'h2d;
  localparam logic [7:0] OFS_AUD  = 8'h2e;
  localparam logic [7:0] OFS_STAT = 8'h2f;
  localparam int         NUM_RW   = 9;

  // Field positions, output_power_control
  localparam int B_GL_TRI   = 7;
  localparam int B_SOG_TRI  = 6;
  localparam int B_SPD_TRI  = 5;
  localparam int B_I2S_TRI  = 4;
  localparam int B_PD_POL   = 3;
  localparam int B_PD_FN_HI = 2;
  localparam int B_PD_FN_LO = 1;
  localparam int B_PD       = 0;
  // power_clock_sync_config
  localparam int B_AUTO_PD  = 7;
  localparam int B_ADDR_LSB = 6;
  localparam int B_MCLK_EXT = 5;
  localparam int B_EMB_SYNC = 4;
  localparam int B_FORCE_DE = 3;
  // audio_serial_config
  localparam int B_CTRL_EN  = 7;
  // link_status
  localparam int B_ST_DE    = 6;
  localparam int B_ST_CLK   = 5;
  localparam int B_ST_MUTE  = 4;
  localparam int B_ST_KEYS  = 3;

  // Reset values
  localparam logic [7:0] RST_OUT = 8'h08;
  localparam logic [7:0] RST_CFG = 8'h80;
  localparam logic [7:0] RST_VHD = 8'h61;
  localparam logic [7:0] RST_HDL = 8'h04;
  localparam logic [7:0] RST_LWH = 8'h05;
  localparam logic [7:0] RST_LWL = 8'h00;
  localparam logic [7:0] RST_SHH = 8'h02;
  localparam logic [7:0] RST_SHL = 8'hd0;
  localparam logic [7:0] RST_AUD = 8'h18;

  // Synchronised pin inputs, index into one vector
  localparam int S_PD    = 0;
  localparam int S_SYNC  = 1;
  localparam int S_DE    = 2;
  localparam int S_CLK   = 3;
  localparam int S_MUTE  = 4;
  localparam int S_KEYS  = 5;
  localparam int S_HS    = 6;
  localparam int S_VS    = 7;
  localparam int NUM_S   = 8;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } opt_reg_req_t;

  typedef logic [NUM_RW-1:0][7:0] opt_regs_t;

  typedef struct packed {
    opt_regs_t        regs;
    logic [NUM_S-1:0] s1;
    logic [NUM_S-1:0] s2;
    logic             hs_d;
    logic             vs_d;
    logic             field;
    logic [11:0]      h_cnt;
    logic [11:0]      v_cnt;
    logic             gde_d;
    logic [7:0]       rdata;
    logic [29:0]      data_out;
    logic             data_oe;
    logic             hs_out;
    logic             hs_oe;
    logic             vs_out;
    logic             vs_oe;
    logic             dclk;
    logic             dclk_oe;
    logic             sog_out;
    logic             sog_oe;
    logic             spd_out;
    logic             spd_oe;
    logic [3:0]       i2s_out;
    logic             i2s_oe;
    logic             avf;
    logic             sav;
    logic             eav;
    logic             pwr_dn;
    logic             seek;
  } opt_state_t;
endpackage

// ==== verilog/opt_ctrl.sv ====
// Output three-state, power-down, timing generator and status registers
// Operation
// R1 - Global three-state bit floats every output except sync-on-green; resets 0.
// R2 - Sync-on-green three-state bit floats that pin; resets 0.
// R3 - Bits 5 and 4 float S/PDIF and I2S pins; reset 0.
// R4 - Polarity bit: 0 pin active low, 1 active high; resets 1.
// R5 - Pin function picks power state and whether sync-on-green floats.
// R6 - Pin function acts only while the power-down pin is asserted.
// R7 - Power-down bit floats syncs, data clock and 30 data outputs.
// R8 - Sync detection and register access keep working during power-down.
// R9 - Auto power-down enters seek mode when no sync is detected.
// R10 - Bit 6 drives the protection bus address LSB.
// R11 - Bit 5 selects external audio master clock.
// R12 - External master clock must be locked to video clock by host.
// R13 - Embedded sync enable inserts start and end of active video codes.
// R14 - Force bit derives display enable from internal timing generator.
// R15 - Interlace offset shifts field 1 by that many lines.
// R16 - Vertical delay counts lines from vsync edge to active video.
// R17 - Ten-bit horizontal delay counts pixels from hsync edge.
// R18 - Twelve-bit line width and screen height, nibble then byte.
// R19 - Control enable puts link control signals on I2S pins.
// R20 - Audio mode and right-justified sample width go to the audio block.
// R21 - Status reports link display enable and link clock presence.
// R22 - Status reports mute and successful key read.
// R23 - Status writes ignored; reads return live status.
module opt_ctrl (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire opt_pkg::opt_reg_req_t reg_req,
  output logic [7:0]                 reg_rdata,
  input  wire logic                  powerdown_pin,
  input  wire logic                  sync_detect,
  input  wire logic                  link_de_det,
  input  wire logic                  link_clk_det,
  input  wire logic                  link_av_mute,
  input  wire logic                  keys_read_ok,
  input  wire logic                  hsync_in,
  input  wire logic                  vsync_in,
  input  wire logic                  link_de_in,
  input  wire logic [29:0]           video_in,
  input  wire logic                  sog_in,
  input  wire logic                  spdif_in,
  input  wire logic [3:0]            i2s_in,
  input  wire logic [3:0]            link_ctrl_in,
  output logic [29:0]                data_out,
  output logic                       data_oe,
  output logic                       hsync_out_pin,
  output logic                       hsync_oe,
  output logic                       vsync_out_pin,
  output logic                       vsync_oe,
  output logic                       data_clock_out,
  output logic                       data_clock_oe,
  output logic                       sync_on_green_out,
  output logic                       sync_on_green_oe,
  output logic                       spdif_out,
  output logic                       spdif_oe,
  output logic [3:0]                 i2s_out,
  output logic                       i2s_oe,
  output logic                       active_video_flag,
  output logic                       sav_flag,
  output logic                       eav_flag,
  output logic                       powered_down,
  output logic                       seek_mode,
  output logic                       protect_addr_lsb,
  output logic                       mclk_ext_sel,
  output logic [1:0]                 audio_mode,
  output logic [4:0]                 audio_width
);

  opt_pkg::opt_state_t st;
  opt_pkg::opt_state_t next_st;

  // Index of a writable register, NUM_RW when unmapped
  function automatic logic [3:0] reg_index(input logic [7:0] a);
    if (a >= opt_pkg::OFS_OUT && a <= opt_pkg::OFS_AUD) begin
      reg_index = 4'(a - opt_pkg::OFS_OUT);
    end else begin
      reg_index = 4'(opt_pkg::NUM_RW);
    end
  endfunction

  logic [7:0]  r_out;
  logic [7:0]  r_cfg;
  logic [7:0]  r_aud;
  logic [5:0]  v_delay;
  logic [9:0]  h_delay;
  logic [11:0] line_w;
  logic [11:0] scr_h;
  logic [7:0]  status;
  logic        pin_act;
  logic        all_hiz;
  logic        vid_hiz;
  logic        hs_edge;
  logic        vs_edge;
  logic [12:0] h_end;
  logic [12:0] v_start;
  logic [12:0] v_end;
  logic        gde;
  logic [3:0]  widx;

  always_comb begin
    r_out   = st.regs[0];
    r_cfg   = st.regs[1];
    r_aud   = st.regs[8];
    v_delay = st.regs[2][7:2];                              // see R16
    h_delay = {st.regs[2][1:0], st.regs[3]};                // see R17
    line_w  = {st.regs[4][3:0], st.regs[5]};                // see R18
    scr_h   = {st.regs[6][3:0], st.regs[7]};                // see R18
    // Live synchronised levels, never latched
    status  = 8'h00;                                        // see R23
    status[opt_pkg::B_ST_DE]   = st.s2[opt_pkg::S_DE];      // see R21
    status[opt_pkg::B_ST_CLK]  = st.s2[opt_pkg::S_CLK];     // see R21
    status[opt_pkg::B_ST_MUTE] = st.s2[opt_pkg::S_MUTE];    // see R22
    status[opt_pkg::B_ST_KEYS] = st.s2[opt_pkg::S_KEYS];    // see R22
    // Pin level read through the polarity bit
    pin_act = r_out[opt_pkg::B_PD_POL] ? st.s2[opt_pkg::S_PD]
                                       : !st.s2[opt_pkg::S_PD]; // see R4
    all_hiz = r_out[opt_pkg::B_GL_TRI] | pin_act;           // see R1, R5, R6
    vid_hiz = all_hiz | r_out[opt_pkg::B_PD];               // see R7
    hs_edge = st.s2[opt_pkg::S_HS] & !st.hs_d;
    vs_edge = st.s2[opt_pkg::S_VS] & !st.vs_d;
    h_end   = 13'(h_delay) + 13'(line_w);
    // Field 1 starts later by the interlace offset
    v_start = 13'(v_delay) + (st.field ? 13'(r_cfg[2:0]) : 13'h0000); // see R15
    v_end   = v_start + 13'(scr_h);
    gde     = (13'(st.h_cnt) >= 13'(h_delay)) && (13'(st.h_cnt) < h_end) &&
              (13'(st.v_cnt) >= v_start) && (13'(st.v_cnt) < v_end);  // see R14
    widx    = reg_index(reg_req.addr);

    next_st = st;
    next_st.s1 = {vsync_in, hsync_in, keys_read_ok, link_av_mute,
                  link_clk_det, link_de_det, sync_detect, powerdown_pin};
    next_st.s2 = st.s1;
    next_st.hs_d = st.s2[opt_pkg::S_HS];
    next_st.vs_d = st.s2[opt_pkg::S_VS];

    // Register port stays live in every power state
    if (reg_req.wr && widx < 4'(opt_pkg::NUM_RW)) begin     // see R8, R23
      next_st.regs[widx] = reg_req.wdata;
    end
    if (reg_req.rd) begin
      if (reg_req.addr == opt_pkg::OFS_STAT) begin
        next_st.rdata = status;                             // see R21, R22
      end else if (widx < 4'(opt_pkg::NUM_RW)) begin
        next_st.rdata = st.regs[widx];
      end else begin
        next_st.rdata = 8'h00;
      end
    end

    // Timing counters run on sync edges even in power-down
    if (hs_edge) begin                                      // see R8
      next_st.h_cnt = 12'h000;
      if (st.v_cnt != 12'hfff) begin
        next_st.v_cnt = st.v_cnt + 12'h001;
      end
    end else if (st.h_cnt != 12'hfff) begin
      next_st.h_cnt = st.h_cnt + 12'h001;
    end
    if (vs_edge) begin
      next_st.v_cnt = 12'h000;
      next_st.field = !st.field;
    end
    next_st.gde_d = gde;

    // Display enable source
    next_st.avf = r_cfg[opt_pkg::B_FORCE_DE] ? gde : link_de_in;     // see R14
    // Code markers at the edges of the generated active window
    next_st.sav = r_cfg[opt_pkg::B_EMB_SYNC] & gde & !st.gde_d;     // see R13
    next_st.eav = r_cfg[opt_pkg::B_EMB_SYNC] & !gde & st.gde_d;     // see R13

    next_st.data_out = video_in;
    next_st.hs_out   = st.s2[opt_pkg::S_HS];
    next_st.vs_out   = st.s2[opt_pkg::S_VS];
    next_st.dclk     = !st.dclk;
    next_st.sog_out  = sog_in;
    next_st.spd_out  = spdif_in;
    next_st.i2s_out  = r_aud[opt_pkg::B_CTRL_EN] ? link_ctrl_in : i2s_in; // see R19

    next_st.data_oe = !vid_hiz;                             // see R1, R7
    next_st.hs_oe   = !vid_hiz;                             // see R7
    next_st.vs_oe   = !vid_hiz;                             // see R7
    next_st.dclk_oe = !vid_hiz;                             // see R7
    next_st.spd_oe  = !(all_hiz | r_out[opt_pkg::B_SPD_TRI]); // see R3
    next_st.i2s_oe  = !(all_hiz | r_out[opt_pkg::B_I2S_TRI]); // see R3
    // Odd function codes also float sync-on-green
    next_st.sog_oe  = !(r_out[opt_pkg::B_SOG_TRI] |
                        (pin_act & r_out[opt_pkg::B_PD_FN_LO])); // see R2, R5
    next_st.seek    = r_cfg[opt_pkg::B_AUTO_PD] & !st.s2[opt_pkg::S_SYNC]; // see R9
    next_st.pwr_dn  = r_out[opt_pkg::B_PD] |
                      (pin_act & !r_out[opt_pkg::B_PD_FN_HI]) |
                      next_st.seek;                         // see R5, R9
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st      <= '0;
      st.regs <= {opt_pkg::RST_AUD, opt_pkg::RST_SHL, opt_pkg::RST_SHH,
                  opt_pkg::RST_LWL, opt_pkg::RST_LWH, opt_pkg::RST_HDL,
                  opt_pkg::RST_VHD, opt_pkg::RST_CFG, opt_pkg::RST_OUT};
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata         = st.rdata;
  assign data_out          = st.data_out;
  assign data_oe           = st.data_oe;
  assign hsync_out_pin     = st.hs_out;
  assign hsync_oe          = st.hs_oe;
  assign vsync_out_pin     = st.vs_out;
  assign vsync_oe          = st.vs_oe;
  assign data_clock_out    = st.dclk;
  assign data_clock_oe     = st.dclk_oe;
  assign sync_on_green_out = st.sog_out;
  assign sync_on_green_oe  = st.sog_oe;
  assign spdif_out         = st.spd_out;
  assign spdif_oe          = st.spd_oe;
  assign i2s_out           = st.i2s_out;
  assign i2s_oe            = st.i2s_oe;
  assign active_video_flag = st.avf;
  assign sav_flag          = st.sav;
  assign eav_flag          = st.eav;
  assign powered_down      = st.pwr_dn;
  assign seek_mode         = st.seek;
  // Straight register bits; the audio clock lock is the host's job
  assign protect_addr_lsb  = st.regs[1][opt_pkg::B_ADDR_LSB];  // see R10
  assign mclk_ext_sel      = st.regs[1][opt_pkg::B_MCLK_EXT];  // see R11, R12
  assign audio_mode        = st.regs[8][6:5];                  // see R20
  assign audio_width       = st.regs[8][4:0];                  // see R20

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_gl_tri;
    r_out[opt_pkg::B_GL_TRI] |=> !data_oe && !spdif_oe && !i2s_oe && !hsync_oe;
  endproperty
  a_gl_tri: assert property (p_gl_tri) else $error("global three-state ignored"); // see R1

  property p_sog_tri;
    r_out[opt_pkg::B_SOG_TRI] |=> !sync_on_green_oe;
  endproperty
  a_sog_tri: assert property (p_sog_tri) else $error("sync-on-green not floated"); // see R2

  property p_pd_bit;
    r_out[opt_pkg::B_PD] && !pin_act && !r_out[opt_pkg::B_SOG_TRI]
      |=> !vsync_oe && !data_clock_oe && sync_on_green_oe && powered_down;
  endproperty
  a_pd_bit: assert property (p_pd_bit) else $error("power-down bit outputs wrong"); // see R7

  property p_pin_idle;
    !pin_act && !r_out[opt_pkg::B_GL_TRI] && !r_out[opt_pkg::B_PD]
      && !r_out[opt_pkg::B_SPD_TRI] |=> data_oe && spdif_oe;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("idle pin floated outputs"); // see R6

  property p_pin_fn;
    pin_act && r_out[2:1] == 2'b10 && !next_st.seek && !r_out[opt_pkg::B_PD]
      && !r_out[opt_pkg::B_SOG_TRI] |=> !data_oe && sync_on_green_oe && !powered_down;
  endproperty
  a_pin_fn: assert property (p_pin_fn) else $error("pin function 10 wrong"); // see R5

  property p_pol;
    r_out[opt_pkg::B_PD_POL] && $stable(r_out) && st.s2[opt_pkg::S_PD]
      && r_out[2:1] == 2'b11 |=> !sync_on_green_oe;
  endproperty
  a_pol: assert property (p_pol) else $error("active-high pin not honoured"); // see R4

  property p_seek;
    r_cfg[opt_pkg::B_AUTO_PD] && !st.s2[opt_pkg::S_SYNC] |=> seek_mode && powered_down;
  endproperty
  a_seek: assert property (p_seek) else $error("seek mode not entered"); // see R9

  property p_ctrl_out;
    r_aud[opt_pkg::B_CTRL_EN] |=> i2s_out == $past(link_ctrl_in);
  endproperty
  a_ctrl_out: assert property (p_ctrl_out) else $error("control signals not on I2S"); // see R19

  property p_force_de;
    r_cfg[opt_pkg::B_FORCE_DE] |=> active_video_flag == $past(gde);
  endproperty
  a_force_de: assert property (p_force_de) else $error("display enable not generated"); // see R14

  property p_sav;
    sav_flag |-> $past(r_cfg[opt_pkg::B_EMB_SYNC]) && $past(gde) && !$past(gde, 2);
  endproperty
  a_sav: assert property (p_sav) else $error("start code misplaced"); // see R13

  property p_status;
    reg_req.rd && reg_req.addr == opt_pkg::OFS_STAT
      |=> reg_rdata[opt_pkg::B_ST_CLK] == $past(st.s2[opt_pkg::S_CLK])
          && reg_rdata[opt_pkg::B_ST_KEYS] == $past(st.s2[opt_pkg::S_KEYS]);
  endproperty
  a_status: assert property (p_status) else $error("status not live"); // see R21, R22

  property p_ro_write;
    reg_req.wr && reg_req.addr == opt_pkg::OFS_STAT |=> st.regs == $past(st.regs);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("status write had effect"); // see R23

  property p_spd_tri;
    r_out[opt_pkg::B_SPD_TRI] |=> !spdif_oe;
  endproperty
  a_spd_tri: assert property (p_spd_tri) else $error("S/PDIF pins not floated"); // see R3

  property p_i2s_tri;
    r_out[opt_pkg::B_I2S_TRI] |=> !i2s_oe;
  endproperty
  a_i2s_tri: assert property (p_i2s_tri) else $error("I2S pins not floated"); // see R3

  property p_gl_sog;
    r_out[opt_pkg::B_GL_TRI] && !r_out[opt_pkg::B_SOG_TRI] && !pin_act |=> sync_on_green_oe;
  endproperty
  a_gl_sog: assert property (p_gl_sog) else $error("global three-state hit sync-on-green"); // see R1

  property p_pin_even;
    pin_act && !r_out[opt_pkg::B_PD_FN_LO] && !r_out[opt_pkg::B_SOG_TRI]
      |=> sync_on_green_oe && !data_oe;
  endproperty
  a_pin_even: assert property (p_pin_even) else $error("even pin function outputs wrong"); // see R5

  property p_pin_dn;
    pin_act && !r_out[opt_pkg::B_PD_FN_HI] |=> powered_down;
  endproperty
  a_pin_dn: assert property (p_pin_dn) else $error("pin did not power down"); // see R5

  property p_pin_off;
    !pin_act && !r_out[opt_pkg::B_PD] && !next_st.seek |=> !powered_down;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("powered down with pin idle"); // see R6

  property p_seek_off;
    !r_cfg[opt_pkg::B_AUTO_PD] |=> !seek_mode;
  endproperty
  a_seek_off: assert property (p_seek_off) else $error("seek mode with auto off"); // see R9

  property p_wr_pd;
    reg_req.wr && reg_req.addr == opt_pkg::OFS_OUT |=> r_out == $past(reg_req.wdata);
  endproperty
  a_wr_pd: assert property (p_wr_pd) else $error("register write lost"); // see R8

  property p_emb_off;
    !r_cfg[opt_pkg::B_EMB_SYNC] |=> !sav_flag && !eav_flag;
  endproperty
  a_emb_off: assert property (p_emb_off) else $error("code marker while disabled"); // see R13

  property p_eav;
    eav_flag |-> $past(r_cfg[opt_pkg::B_EMB_SYNC]) && !$past(gde) && $past(gde, 2);
  endproperty
  a_eav: assert property (p_eav) else $error("end code misplaced"); // see R13

  property p_link_de;
    !r_cfg[opt_pkg::B_FORCE_DE] |=> active_video_flag == $past(link_de_in);
  endproperty
  a_link_de: assert property (p_link_de) else $error("received enable not passed"); // see R14

  property p_i2s_data;
    !r_aud[opt_pkg::B_CTRL_EN] |=> i2s_out == $past(i2s_in);
  endproperty
  a_i2s_data: assert property (p_i2s_data) else $error("audio data not on I2S"); // see R19

endmodule

// ==== test/opt_link_src.sv ====
// Link source model: syncs, link status levels and same-clock data
module opt_link_src (
  input  wire logic clk,
  output logic        sync_detect,
  output logic        link_de_det,
  output logic        link_clk_det,
  output logic        link_av_mute,
  output logic        keys_read_ok,
  output logic        hsync_in,
  output logic        vsync_in,
  output logic        link_de_in,
  output logic [29:0] video_in,
  output logic        sog_in,
  output logic        spdif_in,
  output logic [3:0]  i2s_in,
  output logic [3:0]  link_ctrl_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sync_detect = 1'b1;
    {link_de_det, link_clk_det, link_av_mute, keys_read_ok} = 4'h0;
    {hsync_in, vsync_in, link_de_in} = 3'h0;
    video_in = 30'h2aa55a5a;
    {sog_in, spdif_in} = 2'h3;
    i2s_in = 4'h5;
    link_ctrl_in = 4'ha;
  end

  task set_status(input logic [3:0] s);
    @(posedge clk);
    {link_de_det, link_clk_det, link_av_mute, keys_read_ok} <= s;
  endtask

  task set_sync(input logic v);
    @(posedge clk);
    sync_detect <= v;
  endtask

  task set_de(input logic v);
    @(posedge clk);
    link_de_in <= v;
  endtask

  // Fixed four-cycle sync pulse, leading edge rising
  task sync_pulse(input logic is_v, input int gap);
    @(posedge clk);
    if (is_v) vsync_in <= 1'b1;
    else hsync_in <= 1'b1;
    repeat (4) @(posedge clk);
    hsync_in <= 1'b0;
    vsync_in <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask
endmodule

// ==== test/output_power_timing_ctrl_test.sv ====
// Testbench for output, power-down, timing and status registers
module output_power_timing_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end

  logic clk, sys_rst, powerdown_pin, cnt_en;
  opt_pkg::opt_reg_req_t reg_req;
  logic [7:0] reg_rdata, rd_val;
  logic sync_detect, link_de_det, link_clk_det, link_av_mute, keys_read_ok;
  logic hsync_in, vsync_in, link_de_in, sog_in, spdif_in;
  logic [29:0] video_in, data_out;
  logic [3:0] i2s_in, link_ctrl_in, i2s_out;
  logic data_oe, hsync_out_pin, hsync_oe, vsync_out_pin, vsync_oe, data_clock_out;
  logic data_clock_oe, sync_on_green_out, sync_on_green_oe, spdif_out, spdif_oe, i2s_oe;
  logic active_video_flag, sav_flag, eav_flag, powered_down, seek_mode;
  logic protect_addr_lsb, mclk_ext_sel;
  logic [1:0] audio_mode, f;
  logic [4:0] audio_width;
  logic [6:0] oe_vec;
  int err_count, checks_done;
  // Four-state so an unknown flag cannot count as zero
  integer n_sav, n_eav, n_avf;
  logic [7:0] rst_tbl [9] = '{8'h08, 8'h80, 8'h61, 8'h04, 8'h05, 8'h00, 8'h02, 8'hd0, 8'h18};
  logic [7:0] tri_wr [5] = '{8'h88, 8'h48, 8'h28, 8'h18, 8'h09};
  logic [6:0] tri_oe [5] = '{7'h04, 7'h7b, 7'h7d, 7'h7e, 7'h07};

  assign oe_vec = {data_oe, hsync_oe, vsync_oe, data_clock_oe, sync_on_green_oe, spdif_oe, i2s_oe};

  opt_ctrl u_opt_ctrl (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .powerdown_pin(powerdown_pin), .sync_detect(sync_detect), .link_de_det(link_de_det),
    .link_clk_det(link_clk_det), .link_av_mute(link_av_mute), .keys_read_ok(keys_read_ok),
    .hsync_in(hsync_in), .vsync_in(vsync_in), .link_de_in(link_de_in), .video_in(video_in),
    .sog_in(sog_in), .spdif_in(spdif_in), .i2s_in(i2s_in), .link_ctrl_in(link_ctrl_in),
    .data_out(data_out), .data_oe(data_oe), .hsync_out_pin(hsync_out_pin),
    .hsync_oe(hsync_oe), .vsync_out_pin(vsync_out_pin), .vsync_oe(vsync_oe),
    .data_clock_out(data_clock_out), .data_clock_oe(data_clock_oe),
    .sync_on_green_out(sync_on_green_out), .sync_on_green_oe(sync_on_green_oe),
    .spdif_out(spdif_out), .spdif_oe(spdif_oe), .i2s_out(i2s_out), .i2s_oe(i2s_oe),
    .active_video_flag(active_video_flag), .sav_flag(sav_flag), .eav_flag(eav_flag),
    .powered_down(powered_down), .seek_mode(seek_mode), .protect_addr_lsb(protect_addr_lsb),
    .mclk_ext_sel(mclk_ext_sel), .audio_mode(audio_mode), .audio_width(audio_width));

  opt_link_src u_opt_link_src (.clk(clk), .sync_detect(sync_detect), .link_de_det(link_de_det),
    .link_clk_det(link_clk_det), .link_av_mute(link_av_mute), .keys_read_ok(keys_read_ok),
    .hsync_in(hsync_in), .vsync_in(vsync_in), .link_de_in(link_de_in), .video_in(video_in),
    .sog_in(sog_in), .spdif_in(spdif_in), .i2s_in(i2s_in), .link_ctrl_in(link_ctrl_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) if (cnt_en) begin
    n_sav <= n_sav + sav_flag;
    n_eav <= n_eav + eav_flag;
    n_avf <= n_avf + active_video_flag;
  end

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask

  // Strobe lowered on the answer edge; data sampled once it has landed
  task chk_rd(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    `CHK(n, e, reg_rdata)
  endtask

  // Pin path is two sync stages plus a register, so five edges is ample
  task settle();
    repeat (5) @(posedge clk);
    #1;
  endtask

  task set_pin(input logic v);
    @(posedge clk);
    powerdown_pin <= v;
    settle();
  endtask

  task final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end

  initial begin
    {sys_rst, powerdown_pin, cnt_en, n_sav, n_eav, n_avf, err_count, checks_done} = '0;
    sys_rst = 1'b1;
    reg_req = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    settle();
    for (int i = 0; i < 9; i++) chk_rd("reset value", 8'(8'h26 + i), rst_tbl[i]);
    `CHK("addr lsb", 1'b0, protect_addr_lsb)
    `CHK("width", 5'd24, audio_width)
    `CHK("idle oe", 7'h7f, oe_vec)
    `CHK("data path", 30'h2aa55a5a, data_out)
    rd_val = {4'h0, hsync_out_pin, vsync_out_pin, sync_on_green_out, spdif_out};
    `CHK("out pins", 8'h03, rd_val)
    rd_val[0] = data_clock_out;
    @(posedge clk);
    #1;
    `CHK("data clock", ~rd_val[0], data_clock_out)
    chk_rd("unmapped", 8'h30, 8'h00);
    $display("test reset done");

    for (int i = 0; i < 5; i++) begin
      wr(8'h26, tri_wr[i]);
      settle();
      `CHK("three-state", tri_oe[i], oe_vec)
    end
    `CHK("pd bit", 1'b1, powered_down)
    chk_rd("reg in pd", 8'h26, 8'h09);
    $display("test three-state done");

    for (int i = 0; i < 4; i++) begin
      f = 2'(i);
      wr(8'h26, {5'h01, f, 1'b0});
      set_pin(1'b1);
      `CHK("pin oe", f[0] ? 7'h00 : 7'h04, oe_vec)
      `CHK("pin pd", ~f[1], powered_down)
      set_pin(1'b0);
      `CHK("pin off oe", 7'h7f, oe_vec)
      `CHK("pin off pd", 1'b0, powered_down)
    end
    wr(8'h26, 8'h00);
    settle();
    `CHK("low active", 7'h04, oe_vec)
    set_pin(1'b1);
    `CHK("low inactive", 7'h7f, oe_vec)
    wr(8'h26, 8'h08);
    set_pin(1'b0);
    $display("test pin done");

    wr(8'h27, 8'h60);
    u_opt_link_src.set_sync(1'b0);
    settle();
    `CHK("addr lsb", 1'b1, protect_addr_lsb)
    `CHK("ext mclk", 1'b1, mclk_ext_sel)
    `CHK("no auto", 1'b0, seek_mode)
    wr(8'h27, 8'h80);
    settle();
    `CHK("seek", 1'b1, seek_mode)
    u_opt_link_src.set_sync(1'b1);
    settle();
    `CHK("sync back", 1'b0, seek_mode)
    u_opt_link_src.set_de(1'b1);
    settle();
    `CHK("link de", 1'b1, active_video_flag)
    `CHK("i2s data", 4'h5, i2s_out)
    for (int i = 0; i < 4; i++) begin
      wr(8'h2e, {1'b0, 2'(i), 5'(i + 16)});
      settle();
      `CHK("mode", 2'(i), audio_mode)
      `CHK("rj width", 5'(i + 16), audio_width)
    end
    wr(8'h2e, 8'h98);
    settle();
    `CHK("ctrl on i2s", 4'ha, i2s_out)
    $display("test config done");

    for (int i = 0; i < 5; i++) begin
      u_opt_link_src.set_status(4'(9 * i + 1));
      settle();
      chk_rd("status", 8'h2f, {1'b0, 4'(9 * i + 1), 3'h0});
    end
    wr(8'h2f, 8'hff);
    chk_rd("status ro", 8'h2f, {1'b0, 4'h5, 3'h0});
    $display("test status done");

    wr(8'h28, 8'h04);
    wr(8'h29, 8'h04);
    wr(8'h2a, 8'h00);
    wr(8'h2b, 8'h08);
    wr(8'h2c, 8'h00);
    wr(8'h2d, 8'h02);
    wr(8'h27, 8'h9b);
    // Link enable stays high, so only the generator shapes the window
    // Field 1 first: offset 3 leaves line four; then field 0: lines one and two
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      cnt_en <= 1'b1;
      u_opt_link_src.sync_pulse(1'b1, 20);
      repeat (4) u_opt_link_src.sync_pulse(1'b0, 36);
      repeat (40) @(posedge clk);
      cnt_en <= 1'b0;
      #1;
      `CHK("sav count", 2 * k + 1, n_sav)
      `CHK("eav count", 2 * k + 1, n_eav)
      `CHK("de cycles", 16 * k + 8, n_avf)
    end
    $display("test timing done");
    final_report();
  end
endmodule
